// ### rtl/smlc_checker.v
// Streaming mode legality checker with register port and interrupt
`timescale 1ns/1ps
`include "smlc_consts.vh"

module smlc_checker #(
	parameter LANE_W = 4
) (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire dec_valid,
	input wire [`SMLC_CLS_W-1:0] dec_class,
	input wire dec_vector_form,
	input wire [LANE_W-1:0] dec_lane_index,
	input wire dec_fmov_top_half,
	input wire streaming_mode,
	input wire full_isa_impl,
	input wire full_isa_el_enable,
	input wire trap_fixed_cfg,
	input wire trap_scalable_cfg,
	input wire [`SMLC_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output reg chk_valid,
	output reg chk_legal,
	output reg chk_fixed_exc,
	output reg chk_scal_exc,
	output reg chk_trap,
	output reg irq
);

	// Maps a decoded class onto its legality group
	function [`SMLC_GRP_W-1:0] grp_of;
		input [`SMLC_CLS_W-1:0] cls;
		begin
			case (cls)
				`SMLC_CLS_FIXED_GENERIC: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_TABLE_LOOKUP: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_TABLE_LOOKUP_EXTEND: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_TRANSPOSE_PRIMARY: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_UNZIP_PRIMARY: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_INTERLEAVE_PRIMARY: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_FIXED_UNSIGNED_ARITH: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_FIXED_SHIFT: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_FIXED_DOT_PRODUCT: begin
					grp_of = `SMLC_GRP_FIXED; // [RL9]
				end
				`SMLC_CLS_FLOAT_MULTIPLY_EXTENDED: begin
					grp_of = `SMLC_GRP_SINGLE; // [RL2]
				end
				`SMLC_CLS_FLOAT_RECIPROCAL_ESTIMATE: begin
					grp_of = `SMLC_GRP_SINGLE; // [RL2]
				end
				`SMLC_CLS_FLOAT_RECIPROCAL_STEP: begin
					grp_of = `SMLC_GRP_SINGLE; // [RL2]
				end
				`SMLC_CLS_FLOAT_RECIPROCAL_EXPONENT: begin
					grp_of = `SMLC_GRP_SINGLE; // [RL2]
				end
				`SMLC_CLS_FLOAT_RSQRT_ESTIMATE: begin
					grp_of = `SMLC_GRP_SINGLE; // [RL2]
				end
				`SMLC_CLS_FLOAT_RSQRT_STEP: begin
					grp_of = `SMLC_GRP_SINGLE; // [RL2]
				end
				`SMLC_CLS_SIGNED_LANE_TO_GPR_MOVE: begin
					grp_of = `SMLC_GRP_LANE; // [RL3]
				end
				`SMLC_CLS_UNSIGNED_LANE_TO_GPR_MOVE: begin
					grp_of = `SMLC_GRP_LANE; // [RL3]
				end
				`SMLC_CLS_FLOAT_GPR_RAW_MOVE: begin
					grp_of = `SMLC_GRP_FMOV; // [RL5]
				end
				`SMLC_CLS_VECTOR_ADDRESS_COMPUTE: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_BLOCK_ROUND_DECRYPT: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_BLOCK_ROUND_ENCRYPT: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_BIT_DEPOSIT: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_BIT_EXTRACT: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_BIT_GROUP: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_ACTIVE_ELEMENT_COMPACTION: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_ORDERED_FLOAT_REDUCTION: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_EXPONENTIAL_HELPER: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_TRIG_COEFFICIENT_MAC: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_FLOAT_MATRIX_MAC: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_BRAIN_FLOAT_MATRIX_MAC: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_MATCH_COUNT_VECTOR: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_MATCH_COUNT_SEGMENT: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_GATHER_BYTE_LOAD: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_REPLICATING_BLOCK_LOAD: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_FIRST_FAULT_BYTE_LOAD: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				`SMLC_CLS_SCALABLE_GENERIC: begin
					grp_of = `SMLC_GRP_SCALABLE; // [RL7]
				end
				default: begin
					grp_of = `SMLC_GRP_LEGAL;
				end
			endcase
		end
	endfunction

	reg ctrl_check_en_q;
	reg [`SMLC_EV_W-1:0] status_q;
	reg [`SMLC_EV_W-1:0] status_d;
	reg [`SMLC_EV_W-1:0] mask_q;
	reg [`SMLC_CLS_W-1:0] info_cls_q;
	reg [`SMLC_GRP_W-1:0] info_grp_q;
	reg [`SMLC_COUNT_W-1:0] count_q;

	wire [`SMLC_GRP_W-1:0] grp;
	wire full_ok;
	wire active;
	reg barred;
	wire illegal;
	wire fixed_exc;
	wire scal_exc;
	wire trap_taken;
	wire [`SMLC_EV_W-1:0] events;
	wire reg_write;

	assign grp = grp_of(dec_class);
	assign full_ok = full_isa_impl & full_isa_el_enable;
	assign active = dec_valid & streaming_mode & ctrl_check_en_q;

	// Decides whether the decoded form is barred from streaming mode
	always @* begin
		case (grp)
			`SMLC_GRP_FIXED: begin
				barred = 1'b1; // [RL9]
			end
			`SMLC_GRP_SINGLE: begin
				barred = dec_vector_form; // [RL2]
			end
			`SMLC_GRP_LANE: begin
				barred = |dec_lane_index; // [RL3] [RL4]
			end
			`SMLC_GRP_FMOV: begin
				barred = 1'b0; // [RL5]
			end
			`SMLC_GRP_SCALABLE: begin
				barred = 1'b1; // [RL6]
			end
			default: begin
				barred = 1'b0;
			end
		endcase
	end

	// The full-set option lifts every bar
	assign illegal = active & barred & ~full_ok; // [RL6] [RL9]
	assign fixed_exc = illegal & (grp != `SMLC_GRP_SCALABLE) &
		~trap_fixed_cfg; // [RL1]
	assign scal_exc = illegal & (grp == `SMLC_GRP_SCALABLE) &
		~trap_scalable_cfg; // [RL8]
	assign trap_taken = illegal & ~fixed_exc & ~scal_exc;

	assign events[`SMLC_EV_FIXED_EXC_BIT] = fixed_exc;
	assign events[`SMLC_EV_SCAL_EXC_BIT] = scal_exc;
	assign events[`SMLC_EV_TRAP_BIT] = trap_taken;

	assign reg_write = reg_wr & (reg_addr == `SMLC_OFS_STATUS);

	// Sticky status bits, a new event wins over a write-one clear
	genvar i;
	generate
		for (i = 0; i < `SMLC_EV_W; i = i + 1) begin : g_status
			always @* begin
				if (events[i]) begin
					status_d[i] = 1'b1;
				end else if (reg_write & reg_wdata[i]) begin
					status_d[i] = 1'b0;
				end else begin
					status_d[i] = status_q[i];
				end
			end
		end
	endgenerate

	// Classification result, one cycle after the decode slot
	always @(posedge clk) begin
		if (reset) begin
			chk_valid <= 1'b0;
			chk_legal <= 1'b0;
			chk_fixed_exc <= 1'b0;
			chk_scal_exc <= 1'b0;
			chk_trap <= 1'b0;
		end else if (ce) begin
			chk_valid <= dec_valid;
			chk_legal <= dec_valid & ~illegal;
			chk_fixed_exc <= fixed_exc; // [RL1]
			chk_scal_exc <= scal_exc; // [RL8]
			chk_trap <= trap_taken;
		end
	end

	// Record of the most recent illegal instruction
	always @(posedge clk) begin
		if (reset) begin
			info_cls_q <= `SMLC_CLS_OTHER;
			info_grp_q <= `SMLC_GRP_LEGAL;
			count_q <= {`SMLC_COUNT_W{1'b0}};
		end else if (ce) begin
			if (illegal) begin
				info_cls_q <= dec_class;
				info_grp_q <= grp;
				if (~&count_q) begin
					count_q <= count_q + 1'b1;
				end
			end else if (reg_wr & (reg_addr == `SMLC_OFS_COUNT)) begin
				count_q <= {`SMLC_COUNT_W{1'b0}};
			end
		end
	end

	// Control, status and mask registers
	always @(posedge clk) begin
		if (reset) begin
			ctrl_check_en_q <= `SMLC_CTRL_RESET;
			status_q <= `SMLC_STATUS_RESET;
			mask_q <= `SMLC_MASK_RESET;
			irq <= 1'b0;
		end else if (ce) begin
			status_q <= status_d;
			irq <= |(status_d & mask_q);
			if (reg_wr) begin
				case (reg_addr)
					`SMLC_OFS_CTRL: begin
						ctrl_check_en_q <=
							reg_wdata[`SMLC_CTRL_CHECK_EN_BIT];
					end
					`SMLC_OFS_MASK: begin
						mask_q <= reg_wdata[`SMLC_EV_W-1:0];
						irq <= |(status_d & reg_wdata[`SMLC_EV_W-1:0]);
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Read data stands for one cycle after the read strobe while ce is high, and holds while ce is low
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 32'h00000000;
		end else if (ce) begin
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
					`SMLC_OFS_CTRL: begin
						reg_rdata[`SMLC_CTRL_CHECK_EN_BIT] <=
							ctrl_check_en_q;
					end
					`SMLC_OFS_STATUS: begin
						reg_rdata[`SMLC_EV_W-1:0] <= status_q;
					end
					`SMLC_OFS_MASK: begin
						reg_rdata[`SMLC_EV_W-1:0] <= mask_q;
					end
					`SMLC_OFS_INFO: begin
						reg_rdata[`SMLC_CLS_W-1:0] <= info_cls_q;
						reg_rdata[`SMLC_INFO_GRP_POS+`SMLC_GRP_W-1:
							`SMLC_INFO_GRP_POS] <= info_grp_q;
					end
					`SMLC_OFS_COUNT: begin
						reg_rdata[`SMLC_COUNT_W-1:0] <= count_q;
					end
					default: begin
						reg_rdata <= 32'h00000000;
					end
				endcase
			end
		end
	end

endmodule

// ### rtl/smlc_consts.vh
// Constants for the streaming mode legality checker
// Summary of operation
// RL1 - An illegal fixed-width vector instruction in streaming mode with no trap configured raises the matrix exception.
// RL2 - The multiply-extended and reciprocal estimate, step and exponent pages are barred only in vector form, never as scalars.
// RL3 - Signed and unsigned lane-to-register moves may be barred only when their lane index is nonzero.
// RL4 - Signed and unsigned lane-to-register moves with lane index zero are always legal.
// RL5 - Raw float moves between a 64-bit register and the top half of a 128-bit register are scalar and always legal.
// RL6 - Barred scalable-vector instructions are illegal in streaming mode unless the full-set option is implemented and enabled.
// RL7 - The barred scalable set covers address compute, cipher rounds, bit ops, compaction, ordered reduction, helpers, matrix, histogram and the listed loads.
// RL8 - An illegal scalable-vector instruction in streaming mode with no trap configured raises the matrix exception.
// RL9 - The listed fixed-width vector operations are illegal in streaming mode unless the full-set option is enabled.
`ifndef SMLC_CONSTS_VH
`define SMLC_CONSTS_VH

`define SMLC_CLS_W 6
`define SMLC_CLS_OTHER 6'h00
`define SMLC_CLS_FIXED_GENERIC 6'h01
`define SMLC_CLS_TABLE_LOOKUP 6'h02
`define SMLC_CLS_TABLE_LOOKUP_EXTEND 6'h03
`define SMLC_CLS_TRANSPOSE_PRIMARY 6'h04
`define SMLC_CLS_UNZIP_PRIMARY 6'h05
`define SMLC_CLS_INTERLEAVE_PRIMARY 6'h06
`define SMLC_CLS_FIXED_UNSIGNED_ARITH 6'h07
`define SMLC_CLS_FIXED_SHIFT 6'h08
`define SMLC_CLS_FIXED_DOT_PRODUCT 6'h09
`define SMLC_CLS_FLOAT_MULTIPLY_EXTENDED 6'h0A
`define SMLC_CLS_FLOAT_RECIPROCAL_ESTIMATE 6'h0B
`define SMLC_CLS_FLOAT_RECIPROCAL_STEP 6'h0C
`define SMLC_CLS_FLOAT_RECIPROCAL_EXPONENT 6'h0D
`define SMLC_CLS_FLOAT_RSQRT_ESTIMATE 6'h0E
`define SMLC_CLS_FLOAT_RSQRT_STEP 6'h0F
`define SMLC_CLS_SIGNED_LANE_TO_GPR_MOVE 6'h10
`define SMLC_CLS_UNSIGNED_LANE_TO_GPR_MOVE 6'h11
`define SMLC_CLS_FLOAT_GPR_RAW_MOVE 6'h12
`define SMLC_CLS_VECTOR_ADDRESS_COMPUTE 6'h13
`define SMLC_CLS_BLOCK_ROUND_DECRYPT 6'h14
`define SMLC_CLS_BLOCK_ROUND_ENCRYPT 6'h15
`define SMLC_CLS_BIT_DEPOSIT 6'h16
`define SMLC_CLS_BIT_EXTRACT 6'h17
`define SMLC_CLS_BIT_GROUP 6'h18
`define SMLC_CLS_ACTIVE_ELEMENT_COMPACTION 6'h19
`define SMLC_CLS_ORDERED_FLOAT_REDUCTION 6'h1A
`define SMLC_CLS_EXPONENTIAL_HELPER 6'h1B
`define SMLC_CLS_TRIG_COEFFICIENT_MAC 6'h1C
`define SMLC_CLS_FLOAT_MATRIX_MAC 6'h1D
`define SMLC_CLS_BRAIN_FLOAT_MATRIX_MAC 6'h1E
`define SMLC_CLS_MATCH_COUNT_VECTOR 6'h1F
`define SMLC_CLS_MATCH_COUNT_SEGMENT 6'h20
`define SMLC_CLS_GATHER_BYTE_LOAD 6'h21
`define SMLC_CLS_REPLICATING_BLOCK_LOAD 6'h22
`define SMLC_CLS_FIRST_FAULT_BYTE_LOAD 6'h23
`define SMLC_CLS_SCALABLE_GENERIC 6'h24

`define SMLC_GRP_W 3
`define SMLC_GRP_LEGAL 3'h0
`define SMLC_GRP_FIXED 3'h1
`define SMLC_GRP_SINGLE 3'h2
`define SMLC_GRP_LANE 3'h3
`define SMLC_GRP_FMOV 3'h4
`define SMLC_GRP_SCALABLE 3'h5

`define SMLC_ADDR_W 8
`define SMLC_OFS_CTRL 8'h00
`define SMLC_OFS_STATUS 8'h04
`define SMLC_OFS_MASK 8'h08
`define SMLC_OFS_INFO 8'h0C
`define SMLC_OFS_COUNT 8'h10

`define SMLC_CTRL_CHECK_EN_BIT 0
`define SMLC_CTRL_RESET 1'h1
`define SMLC_EV_W 3
`define SMLC_EV_FIXED_EXC_BIT 0
`define SMLC_EV_SCAL_EXC_BIT 1
`define SMLC_EV_TRAP_BIT 2
`define SMLC_STATUS_RESET 3'h0
`define SMLC_MASK_RESET 3'h0
`define SMLC_INFO_GRP_POS 8
`define SMLC_COUNT_W 16

`endif

// ### testbench/smlc_checker_sva.sv
// Assertions on the legality checker ports
`timescale 1ns/1ps
module smlc_checker_sva #(
	parameter LANE_W = 4
) (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire dec_valid,
	input wire [5:0] dec_class,
	input wire dec_vector_form,
	input wire [LANE_W-1:0] dec_lane_index,
	input wire streaming_mode,
	input wire full_isa_impl,
	input wire full_isa_el_enable,
	input wire trap_fixed_cfg,
	input wire trap_scalable_cfg,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire chk_valid,
	input wire chk_legal,
	input wire chk_fixed_exc,
	input wire chk_scal_exc,
	input wire chk_trap
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
reg en_q;
wire go = ce && dec_valid;
wire full = full_isa_impl && full_isa_el_enable;
wire bar = streaming_mode && en_q && !full;
wire ln = dec_class == 6'h10 || dec_class == 6'h11;
wire sv = dec_class >= 6'h13 && dec_class <= 6'h24;
wire fx = dec_class >= 6'h01 && dec_class <= 6'h09;
wire sg = dec_class >= 6'h0A && dec_class <= 6'h0F;
// Shadow of the check enable bit
always @(posedge clk)
	if (reset) en_q <= 1'b1;
	else if (ce && reg_wr && reg_addr == 8'h00) en_q <= reg_wdata[0];
a_valid_follow: assert property (ce |=> chk_valid == $past(dec_valid))
	else $error("result pulse does not follow decode slot");
a_lane_zero: assert property (
	go && streaming_mode && ln && dec_lane_index == 0 |=> chk_legal)
	else $error("lane zero move refused");
a_lane_bar: assert property (
	go && bar && ln && dec_lane_index != 0 |=> !chk_legal)
	else $error("nonzero lane move accepted");
a_single_ok: assert property (
	go && sg && !dec_vector_form |=> chk_legal)
	else $error("scalar form refused");
a_fmov_ok: assert property (go && dec_class == 6'h12 |=> chk_legal)
	else $error("raw float move refused");
a_fixed_exc: assert property (
	go && bar && fx && !trap_fixed_cfg |=> chk_fixed_exc && !chk_legal)
	else $error("fixed op exception missing");
a_scal_exc: assert property (
	go && bar && sv && !trap_scalable_cfg |=> chk_scal_exc && !chk_trap)
	else $error("scalable op exception missing");
a_full_ok: assert property (
	go && streaming_mode && full && (sv || fx) |=> chk_legal)
	else $error("full set option ignored");
endmodule
bind smlc_checker smlc_checker_sva #(.LANE_W(LANE_W)) u_sva (.clk(clk),
	.reset(reset), .ce(ce), .dec_valid(dec_valid), .dec_class(dec_class),
	.dec_vector_form(dec_vector_form), .dec_lane_index(dec_lane_index),
	.streaming_mode(streaming_mode), .full_isa_impl(full_isa_impl),
	.full_isa_el_enable(full_isa_el_enable), .trap_fixed_cfg(trap_fixed_cfg),
	.trap_scalable_cfg(trap_scalable_cfg), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .chk_valid(chk_valid),
	.chk_legal(chk_legal), .chk_fixed_exc(chk_fixed_exc),
	.chk_scal_exc(chk_scal_exc), .chk_trap(chk_trap));

// ### testbench/smlc_exc_model.sv
// Exception unit model counting exceptions taken
`timescale 1ns/1ps
module smlc_exc_model (
	input wire clk,
	input wire fixed_exc,
	input wire scal_exc,
	output integer n_taken
);
initial n_taken = 0;
always @(posedge clk)
	if (fixed_exc || scal_exc) n_taken <= n_taken + 1;
endmodule

// ### testbench/smlc_checker_tb_top.sv
// Testbench for the streaming mode legality checker
`timescale 1ns/1ps
module smlc_checker_tb_top;
logic clk = 0, reset = 1, ce = 1, dv = 0, vf = 0, top = 0;
logic sm = 0, fi = 0, fe = 0, tf = 0, ts = 0, wr = 0, rd = 0;
logic [5:0] cls = 0;
logic [3:0] ln = 0;
logic [7:0] ad = 0;
logic [31:0] wd = 0;
wire [31:0] rdat;
wire ov, ol, ofx, osx, otr, irq;
integer n_taken, failures = 0, n_compared = 0, n_exp = 0, c;
always #5 clk = ~clk;
smlc_checker u_smlc_checker (.clk(clk), .reset(reset), .ce(ce),
	.dec_valid(dv), .dec_class(cls), .dec_vector_form(vf),
	.dec_lane_index(ln), .dec_fmov_top_half(top), .streaming_mode(sm),
	.full_isa_impl(fi), .full_isa_el_enable(fe), .trap_fixed_cfg(tf),
	.trap_scalable_cfg(ts), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
	.reg_rd(rd), .reg_rdata(rdat), .chk_valid(ov), .chk_legal(ol),
	.chk_fixed_exc(ofx), .chk_scal_exc(osx), .chk_trap(otr), .irq(irq));
smlc_exc_model u_smlc_exc_model (.clk(clk), .fixed_exc(ofx),
	.scal_exc(osx), .n_taken(n_taken));
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
	n_compared++;
	if (s !== e) begin
		failures++;
		$display("[ERR] %s exp %h seen %h", nm, e, s);
	end
endtask
task wrap_up;
	if (failures == 0 && n_compared > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
// Mode m is {streaming, impl, el enable, trap fixed, trap scalable}
task send(input int k, input logic v, input logic [3:0] l,
	input logic [4:0] m);
	logic fx, sv, ill, t;
	fx = (k >= 1 && k <= 9) || (k >= 10 && k <= 15 && v);
	fx = fx || ((k == 16 || k == 17) && l != 4'h0);
	sv = k >= 19 && k <= 36;
	ill = m[4] && (fx || sv) && !(m[3] && m[2]);
	t = fx ? m[1] : m[0];
	@(posedge clk);
	{sm, fi, fe, tf, ts} <= m;
	dv <= 1;
	cls <= k[5:0];
	vf <= v;
	ln <= l;
	@(posedge clk);
	dv <= 0;
	#1;
	chk("valid", ov, 1);
	chk("legal", ol, !ill);
	chk("fixed_exc", ofx, ill && fx && !t);
	chk("scal_exc", osx, ill && sv && !t);
	chk("trap", otr, ill && t);
	if (ill && !t) n_exp++;
endtask
task wreg(input logic [7:0] a, input logic [31:0] d);
	@(posedge clk);
	wr <= 1;
	ad <= a;
	wd <= d;
	@(posedge clk);
	wr <= 0;
	#1;
endtask
task rreg(input logic [7:0] a, input logic [31:0] e);
	@(posedge clk);
	rd <= 1;
	ad <= a;
	@(posedge clk);
	rd <= 0;
	#1 chk("rdata", rdat, e);
endtask
task t_regs;
	rreg(8'h00, 32'h1);
	rreg(8'h04, 32'h0);
	rreg(8'h08, 32'h0);
	rreg(8'h10, 32'h0);
	rreg(8'h20, 32'h0);
endtask
task t_fixed;
	for (c = 1; c <= 9; c++) send(c, 1, 0, 5'h10);
	send(2, 1, 0, 5'h1C);
	send(2, 1, 0, 5'h12);
	send(2, 1, 0, 5'h00);
endtask
task t_single;
	for (c = 10; c <= 15; c++) begin
		send(c, 0, 0, 5'h10);
		if (c != 13) send(c, 1, 0, 5'h10);
	end
endtask
task t_lane;
	for (c = 16; c <= 17; c++) begin
		send(c, 1, 4'h0, 5'h10);
		send(c, 1, 4'h3, 5'h10);
		send(c, 1, 4'hF, 5'h10);
	end
	@(posedge clk);
	top <= 1;
	send(18, 1, 0, 5'h10);
endtask
task t_scal;
	for (c = 19; c <= 36; c++) send(c, 1, 0, 5'h10);
	send(36, 1, 0, 5'h18);
	send(36, 1, 0, 5'h14);
	send(36, 1, 0, 5'h1C);
	send(19, 1, 0, 5'h11);
endtask
task t_hold;
	@(posedge clk);
	{sm, fi, fe, tf, ts} <= 5'h12;
	dv <= 1;
	cls <= 6'h02;
	vf <= 1;
	ln <= 0;
	@(posedge clk);
	ce <= 0;
	cls <= 6'h00;
	repeat (2) @(posedge clk);
	#1;
	chk("hold_trap", otr, 1);
	chk("hold_legal", ol, 0);
	chk("hold_valid", ov, 1);
	@(posedge clk);
	ce <= 1;
	dv <= 0;
	@(posedge clk);
	#1;
	chk("hold_end", otr, 0);
	chk("hold_end_valid", ov, 0);
endtask
task t_irq;
	wreg(8'h04, 32'h7);
	wreg(8'h10, 32'h0);
	wreg(8'h08, 32'h1);
	chk("irq", irq, 0);
	send(2, 1, 0, 5'h10);
	chk("irq", irq, 1);
	rreg(8'h0C, 32'h102);
	wreg(8'h04, 32'h1);
	chk("irq", irq, 0);
	send(20, 1, 0, 5'h10);
	chk("irq", irq, 0);
	rreg(8'h04, 32'h2);
	rreg(8'h10, 32'h2);
endtask
initial begin
	#200000;
	failures++;
	wrap_up;
end
initial begin
	repeat (20) @(posedge clk);
	reset <= 0;
	t_regs;
	t_fixed;
	t_single;
	t_lane;
	t_scal;
	t_hold;
	t_irq;
	@(posedge clk);
	chk("taken", n_taken, n_exp);
	wrap_up;
end
endmodule
